/* msb_defines.svh */
// Constants for the memory controller side-band handshake block.
// Assumes one core clock; pin inputs are synchronised inside the top module.
// Notes on behaviour
// - Core accepts stop only when fully quiescent
// - Core may deny a clock-stop request
// - Core drives activity while work pending
// - Register bus has own stop handshake
// - Register bus may deny its stop
// - Register bus drives its own activity
// - Five-bit target frequency on both handshakes
// - Frequency request raised once update safe
// - Abort request stops link-error retries
// - Abort acknowledge only with nothing outstanding
// - Self-test port uses own low reset
// - Interrupt on correctable internal RAM error
// - Interrupt on uncorrectable internal RAM error
// - Interrupt on corrected DRAM burst error
// - Interrupt on uncorrectable DRAM burst failure
// - Interrupt on failed permissions check
// - Interrupt on disallowed programming request
// - Interrupt on link failure with recovery
// - Low-power requests with wakeup code, await acknowledge
`ifndef MSB_DEFINES_SVH
`define MSB_DEFINES_SVH

`define MSB_FREQ_W       5
`define MSB_WAKE_W       4
`define MSB_NUM_INT      7
`define MSB_NUM_SYNC     9
`define MSB_SY_QREQN     0
`define MSB_SY_QREQN_RB  1
`define MSB_SY_CC_ACK    2
`define MSB_SY_DFI_FACK  3
`define MSB_SY_ABORT     4
`define MSB_SY_LP_ACK    5
`define MSB_SY_RDLVL_REQ 6
`define MSB_SY_RDLVL_RSP 7
`define MSB_SY_MBIST_REQ 8
`define MSB_SYNC_RST     9'h003
`define MSB_INT_RAM_C    0
`define MSB_INT_RAM_U    1
`define MSB_INT_DRAM_C   2
`define MSB_INT_DRAM_U   3
`define MSB_INT_ACCESS   4
`define MSB_INT_PROG     5
`define MSB_INT_LINK     6

`endif

/* msb_pkg.sv */
// Types shared by the side-band handshake block.
// Assumes msb_defines.svh supplies the numeric constants.
package msb_pkg;

  // Gray along run, request, stopped, exit; deny branch off the path
  typedef enum logic [2:0] {
    MSB_Q_RUN     = 3'h0,
    MSB_Q_REQ     = 3'h1,
    MSB_Q_STOPPED = 3'h3,
    MSB_Q_EXIT    = 3'h2,
    MSB_Q_DENIED  = 3'h5
  } msb_qstate_e;

  typedef enum logic [1:0] {
    MSB_F_IDLE = 2'h0,
    MSB_F_SAFE = 2'h1,
    MSB_F_REQ  = 2'h3,
    MSB_F_DROP = 2'h2
  } msb_fstate_e;

endpackage

/* msb_qch_if.sv */
// Carrier between the top module and one clock-stop handshake engine.
// Assumes qreqn here is already synchronised to the core clock.
`timescale 1ns/1ps
interface msb_qch_if;
  logic qreqn_s;
  logic busy;
  logic deny_en;
  logic qacceptn;
  logic qdeny;
  logic qactive;
  logic stopped;

  modport engine (input qreqn_s, input busy, input deny_en,
                  output qacceptn, output qdeny, output qactive, output stopped);
  modport owner  (output qreqn_s, output busy, output deny_en,
                  input qacceptn, input qdeny, input qactive, input stopped);
endinterface

/* msb_qchan.sv */
// One four-phase clock-stop handshake engine, used for core and register bus.
// Assumes the request arrives synchronised and busy is on the same clock.
`timescale 1ns/1ps
module msb_qchan (
  input  wire logic   clock,
  input  wire logic   nrst,
  msb_qch_if.engine   q
);

  msb_pkg::msb_qstate_e state_q;
  msb_pkg::msb_qstate_e state_d;
  logic                 qactive_q;
  logic                 qacceptn_q;
  logic                 qdeny_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      msb_pkg::MSB_Q_RUN:
        if (!q.qreqn_s)
          state_d = msb_pkg::MSB_Q_REQ;
      msb_pkg::MSB_Q_REQ:
        if (q.qreqn_s)
          state_d = msb_pkg::MSB_Q_RUN;
        else if (q.deny_en)
          state_d = msb_pkg::MSB_Q_DENIED;
        else if (!q.busy)
          state_d = msb_pkg::MSB_Q_STOPPED;
      msb_pkg::MSB_Q_STOPPED:
        if (q.qreqn_s)
          state_d = msb_pkg::MSB_Q_EXIT;
      msb_pkg::MSB_Q_EXIT:
        state_d = msb_pkg::MSB_Q_RUN;
      msb_pkg::MSB_Q_DENIED:
        if (q.qreqn_s)
          state_d = msb_pkg::MSB_Q_RUN;
      default:
        state_d = msb_pkg::MSB_Q_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      state_q   <= msb_pkg::MSB_Q_RUN;
      qactive_q <= 1'b0;
      qacceptn_q <= 1'b1;
      qdeny_q    <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      qacceptn_q <= (state_d != msb_pkg::MSB_Q_STOPPED);
      qdeny_q    <= (state_d == msb_pkg::MSB_Q_DENIED);
      qactive_q <= q.busy;
    end
  end

  // Answers are registered from the next state so the pins see no decode glitches
  assign q.qacceptn = qacceptn_q;
  assign q.qdeny    = qdeny_q;
  assign q.qactive  = qactive_q;
  assign q.stopped  = (state_q == msb_pkg::MSB_Q_STOPPED);

  AST_ACCEPT_IDLE: assert property (@(posedge clock) disable iff (!nrst)
    $fell(q.qacceptn) |-> !q.qreqn_s && !$past(q.busy) && !$past(q.deny_en))
    else $error("stop accepted while busy or deny requested");

  AST_NO_BOTH: assert property (@(posedge clock) disable iff (!nrst)
    !(q.qdeny && !q.qacceptn))
    else $error("accept and deny both asserted");

  AST_DENY_REL: assert property (@(posedge clock) disable iff (!nrst)
    q.qdeny && q.qreqn_s |=> !q.qdeny)
    else $error("deny not released after request withdrawn");

  AST_ACC_REL: assert property (@(posedge clock) disable iff (!nrst)
    !q.qacceptn && q.qreqn_s |-> ##2 q.qacceptn)
    else $error("accept not released two cycles after request withdrawn");

endmodule

/* msb_sideband.sv */
// Side-band handshakes and event outputs of the memory controller.
// Pin inputs cross two flops; core-side inputs share the clock.
`timescale 1ns/1ps
`include "msb_defines.svh"
module msb_sideband #(
  parameter int OUT_W = 8,
  parameter int CS_W  = 2
) (
  input  wire logic                     clock,
  input  wire logic                     nrst,
  // Core clock-stop handshake
  input  wire logic                     qreqn,
  output logic                          qacceptn,
  output logic                          qdeny,
  output logic                          qactive,
  input  wire logic                     core_busy,
  input  wire logic                     core_deny_en,
  // Register-bus clock-stop handshake
  input  wire logic                     qreqn_regbus,
  output logic                          qacceptn_regbus,
  output logic                          qdeny_regbus,
  output logic                          qactive_regbus,
  input  wire logic                     regbus_busy,
  input  wire logic                     regbus_deny_en,
  // Frequency change
  input  wire logic                     freq_change_start,
  input  wire logic [`MSB_FREQ_W-1:0]   freq_target,
  output logic      [`MSB_FREQ_W-1:0]   clkctl_target_freq,
  output logic                          clkctl_freq_update_req,
  input  wire logic                     clkctl_freq_update_ack,
  output logic      [`MSB_FREQ_W-1:0]   dfi_frequency,
  output logic                          dfi_freq_change_req,
  input  wire logic                     dfi_freq_change_ack,
  output logic                          freq_change_done,
  // Abort
  input  wire logic [OUT_W-1:0]         txn_outstanding,
  input  wire logic                     abort_req,
  output logic                          abort_ack,
  output logic                          retry_enable,
  // Low power
  input  wire logic                     lp_ctrl_want,
  input  wire logic                     lp_data_want,
  input  wire logic [`MSB_WAKE_W-1:0]   lp_wakeup_code,
  output logic                          dfi_lp_ctrl_req,
  output logic                          dfi_lp_data_req,
  output logic      [`MSB_WAKE_W-1:0]   dfi_lp_wakeup,
  input  wire logic                     dfi_lp_ack,
  output logic                          lp_granted,
  // Read-eye training
  input  wire logic                     dfi_rdlvl_req,
  input  wire logic [CS_W-1:0]          dfi_rdlvl_cs_n,
  input  wire logic                     dfi_rdlvl_periodic,
  input  wire logic                     rdlvl_allow,
  output logic                          dfi_rdlvl_en,
  input  wire logic                     dfi_rdlvl_resp,
  output logic      [CS_W-1:0]          rdlvl_target_cs_n,
  output logic                          rdlvl_is_periodic,
  output logic                          rdlvl_done,
  // Memory self-test
  input  wire logic                     mbistresetn,
  input  wire logic                     mbistreq,
  output logic                          mbistack,
  // Events and interrupts
  input  wire logic [`MSB_NUM_INT-1:0]  event_pulse,
  input  wire logic [`MSB_NUM_INT-1:0]  int_clear,
  output logic                          ram_ecc_errc_int,
  output logic                          ram_ecc_errd_int,
  output logic                          dram_ecc_errc_int,
  output logic                          dram_ecc_errd_int,
  output logic                          failed_access_int,
  output logic                          failed_prog_int,
  output logic                          link_err_int
);

  if (OUT_W < 1 || OUT_W > 16 || CS_W < 1)
  begin : g_bad_param
    $error("OUT_W or CS_W out of range");
  end

  // Two-flop synchronisers for every pin-side level
  logic [`MSB_NUM_SYNC-1:0] sync1_q;
  logic [`MSB_NUM_SYNC-1:0] sync2_q;
  logic [`MSB_NUM_SYNC-1:0] pin_raw;
  logic [CS_W:0]            rdcs_s1_q;
  logic [CS_W:0]            rdcs_s2_q;

  assign pin_raw = {mbistreq, dfi_rdlvl_resp, dfi_rdlvl_req, dfi_lp_ack, abort_req,
                    dfi_freq_change_ack, clkctl_freq_update_ack, qreqn_regbus, qreqn};

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      sync1_q <= `MSB_SYNC_RST;
      sync2_q <= `MSB_SYNC_RST;
      rdcs_s1_q <= '0;
      rdcs_s2_q <= '0;
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      rdcs_s1_q <= {dfi_rdlvl_cs_n, dfi_rdlvl_periodic};
      rdcs_s2_q <= rdcs_s1_q;
    end
  end

  wire cc_ack_s    = sync2_q[`MSB_SY_CC_ACK];
  wire dfi_fack_s  = sync2_q[`MSB_SY_DFI_FACK];
  wire abort_s     = sync2_q[`MSB_SY_ABORT];
  wire lp_ack_s    = sync2_q[`MSB_SY_LP_ACK];
  wire rdlvl_req_s = sync2_q[`MSB_SY_RDLVL_REQ];
  wire rdlvl_rsp_s = sync2_q[`MSB_SY_RDLVL_RSP];
  wire mbist_req_s = sync2_q[`MSB_SY_MBIST_REQ];

  // Clock-stop engines; core stays busy while anything is outstanding
  msb_qch_if q_core ();
  msb_qch_if q_rb ();

  msb_pkg::msb_fstate_e   fstate_q;
  msb_pkg::msb_fstate_e   fstate_d;
  logic [`MSB_FREQ_W-1:0] freq_q;
  logic                   fdone_q;
  logic                   freq_req_q;
  wire nothing_outstanding = (txn_outstanding == '0);

  assign q_core.qreqn_s = sync2_q[`MSB_SY_QREQN];
  assign q_core.busy    = core_busy || !nothing_outstanding;
  assign q_core.deny_en = core_deny_en || (fstate_q != msb_pkg::MSB_F_IDLE);
  assign q_rb.qreqn_s   = sync2_q[`MSB_SY_QREQN_RB];
  assign q_rb.busy      = regbus_busy;
  assign q_rb.deny_en   = regbus_deny_en;

  msb_qchan u_qch_core (
    .clock (clock),
    .nrst  (nrst),
    .q     (q_core.engine)
  );

  msb_qchan u_qch_regbus (
    .clock (clock),
    .nrst  (nrst),
    .q     (q_rb.engine)
  );

  assign qacceptn        = q_core.qacceptn;
  assign qdeny           = q_core.qdeny;
  assign qactive         = q_core.qactive;
  assign qacceptn_regbus = q_rb.qacceptn;
  assign qdeny_regbus    = q_rb.qdeny;
  assign qactive_regbus  = q_rb.qactive;

  // Frequency change: wait for quiet, then request both partners together.
  // A change is never started while the core clock is stopped.

  wire both_acked  = cc_ack_s && dfi_fack_s;
  wire both_ack_lo = !cc_ack_s && !dfi_fack_s;
  wire freq_launch = freq_change_start && (fstate_q == msb_pkg::MSB_F_IDLE) && !q_core.stopped;

  always_comb
  begin
    fstate_d = fstate_q;
    case (fstate_q)
      msb_pkg::MSB_F_IDLE:
        if (freq_launch)
          fstate_d = msb_pkg::MSB_F_SAFE;
      msb_pkg::MSB_F_SAFE:
        if (nothing_outstanding && !core_busy)
          fstate_d = msb_pkg::MSB_F_REQ;
      msb_pkg::MSB_F_REQ:
        if (both_acked)
          fstate_d = msb_pkg::MSB_F_DROP;
      msb_pkg::MSB_F_DROP:
        if (both_ack_lo)
          fstate_d = msb_pkg::MSB_F_IDLE;
      default:
        fstate_d = msb_pkg::MSB_F_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      fstate_q <= msb_pkg::MSB_F_IDLE;
      freq_q   <= '0;
      fdone_q  <= 1'b0;
      freq_req_q <= 1'b0;
    end
    else
    begin
      fstate_q <= fstate_d;
      freq_req_q <= (fstate_d == msb_pkg::MSB_F_REQ);
      if (freq_launch)
        freq_q <= freq_target;
      fdone_q  <= (fstate_q == msb_pkg::MSB_F_DROP) && both_ack_lo;
    end
  end

  assign clkctl_target_freq     = freq_q;
  assign dfi_frequency          = freq_q;
  assign clkctl_freq_update_req = freq_req_q;
  assign dfi_freq_change_req    = freq_req_q;
  assign freq_change_done       = fdone_q;

  // Abort: retries stop at once, acknowledge waits for the queue to drain
  logic abort_ack_q;
  logic retry_en_q;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      abort_ack_q <= 1'b0;
      retry_en_q  <= 1'b1;
    end
    else
    begin
      retry_en_q  <= !abort_s;
      abort_ack_q <= abort_s && nothing_outstanding;
    end
  end

  assign abort_ack    = abort_ack_q;
  assign retry_enable = retry_en_q;

  // Low power: wakeup code is frozen while any request is held
  logic                   lp_ctrl_q;
  logic                   lp_data_q;
  logic [`MSB_WAKE_W-1:0] lp_wake_q;
  logic                   lp_grant_q;

  wire lp_any_q = lp_ctrl_q || lp_data_q;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      lp_ctrl_q  <= 1'b0;
      lp_data_q  <= 1'b0;
      lp_wake_q  <= '0;
      lp_grant_q <= 1'b0;
    end
    else
    begin
      lp_ctrl_q  <= lp_ctrl_want;
      lp_data_q  <= lp_data_want;
      if (!lp_any_q)
        lp_wake_q <= lp_wakeup_code;
      lp_grant_q <= lp_any_q && lp_ack_s;
    end
  end

  assign dfi_lp_ctrl_req = lp_ctrl_q;
  assign dfi_lp_data_req = lp_data_q;
  assign dfi_lp_wakeup   = lp_wake_q;
  assign lp_granted      = lp_grant_q;

  // Read-eye training: targets captured as the request is first seen
  logic            rdlvl_en_q;
  logic            rdlvl_req_d1_q;
  logic [CS_W-1:0] rdlvl_cs_q;
  logic            rdlvl_per_q;
  logic            rdlvl_done_q;

  wire rdlvl_rise = rdlvl_req_s && !rdlvl_req_d1_q;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      rdlvl_en_q     <= 1'b0;
      rdlvl_req_d1_q <= 1'b0;
      rdlvl_cs_q     <= '1;
      rdlvl_per_q    <= 1'b0;
      rdlvl_done_q   <= 1'b0;
    end
    else
    begin
      rdlvl_req_d1_q <= rdlvl_req_s;
      if (rdlvl_rise)
      begin
        rdlvl_cs_q  <= rdcs_s2_q[CS_W:1];
        rdlvl_per_q <= rdcs_s2_q[0];
      end
      rdlvl_en_q   <= rdlvl_req_s && rdlvl_allow && !rdlvl_rsp_s;
      rdlvl_done_q <= rdlvl_en_q && rdlvl_rsp_s;
    end
  end

  assign dfi_rdlvl_en      = rdlvl_en_q;
  assign rdlvl_target_cs_n = rdlvl_cs_q;
  assign rdlvl_is_periodic = rdlvl_per_q;
  assign rdlvl_done        = rdlvl_done_q;

  // Self-test acknowledge has a reset of its own so test can restart it
  logic mbist_ack_q;

  always_ff @(posedge clock)
  begin
    if (!mbistresetn)
      mbist_ack_q <= 1'b0;
    else
      mbist_ack_q <= mbist_req_s;
  end

  assign mbistack = mbist_ack_q;

  // Sticky interrupts; an event in the clearing cycle wins
  logic [`MSB_NUM_INT-1:0] int_q;

  for (genvar i = 0; i < `MSB_NUM_INT; i++)
  begin : g_int
    always_ff @(posedge clock)
    begin
      if (!nrst)
        int_q[i] <= 1'b0;
      else
        int_q[i] <= event_pulse[i] || (int_q[i] && !int_clear[i]);
    end
  end

  assign ram_ecc_errc_int  = int_q[`MSB_INT_RAM_C];
  assign ram_ecc_errd_int  = int_q[`MSB_INT_RAM_U];
  assign dram_ecc_errc_int = int_q[`MSB_INT_DRAM_C];
  assign dram_ecc_errd_int = int_q[`MSB_INT_DRAM_U];
  assign failed_access_int = int_q[`MSB_INT_ACCESS];
  assign failed_prog_int   = int_q[`MSB_INT_PROG];
  assign link_err_int      = int_q[`MSB_INT_LINK];

  AST_ABORT_DRAIN: assert property (@(posedge clock) disable iff (!nrst)
    abort_ack |-> $past(txn_outstanding) == '0 && $past(abort_req, 3))
    else $error("abort acknowledged with work outstanding");

  AST_RETRY_OFF: assert property (@(posedge clock) disable iff (!nrst)
    abort_req |-> ##3 !retry_enable || !$past(abort_req, 2))
    else $error("retries not stopped three cycles after abort");

  AST_FREQ_SAFE: assert property (@(posedge clock) disable iff (!nrst)
    $rose(clkctl_freq_update_req) |-> $past(txn_outstanding) == '0 && !$past(core_busy))
    else $error("frequency request raised while not safe");

  AST_FREQ_STABLE: assert property (@(posedge clock) disable iff (!nrst)
    clkctl_freq_update_req |-> $stable(clkctl_target_freq) && dfi_frequency == clkctl_target_freq)
    else $error("target frequency moved during request");

  AST_FREQ_ACK: assert property (@(posedge clock) disable iff (!nrst)
    (clkctl_freq_update_req && clkctl_freq_update_ack && dfi_freq_change_ack) [*3]
      |=> !clkctl_freq_update_req)
    else $error("frequency request held after both acknowledges");

  AST_LP_WAKE: assert property (@(posedge clock) disable iff (!nrst)
    $past(dfi_lp_ctrl_req || dfi_lp_data_req) |-> $stable(dfi_lp_wakeup))
    else $error("wakeup code changed during low-power request");

  AST_INT_STICKY: assert property (@(posedge clock) disable iff (!nrst)
    link_err_int && !int_clear[`MSB_INT_LINK] |=> link_err_int)
    else $error("interrupt dropped without a clear");

  AST_INT_SET: assert property (@(posedge clock) disable iff (!nrst)
    event_pulse[`MSB_INT_RAM_C] |=> ram_ecc_errc_int)
    else $error("correctable RAM event not flagged");

  AST_MBIST_RST: assert property (@(posedge clock)
    !mbistresetn |=> !mbistack)
    else $error("self-test acknowledge survived its reset");

endmodule

/* msb_partner.sv */
// Far-side model: clock control and PHY answering the block's side-band requests.
// Assumes requests are levels on the core clock; each answer follows its request after a delay.
`timescale 1ns/1ps
module msb_partner (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic slow,
  input  wire logic clkctl_freq_update_req,
  input  wire logic dfi_freq_change_req,
  input  wire logic dfi_lp_ctrl_req,
  input  wire logic dfi_lp_data_req,
  input  wire logic dfi_rdlvl_en,
  output logic      clkctl_freq_update_ack,
  output logic      dfi_freq_change_ack,
  output logic      dfi_lp_ack,
  output logic      dfi_rdlvl_resp
);
  logic [3:0] req_v;
  logic [3:0] ack_q;
  logic [3:0] cnt_q [4];

  assign req_v = {dfi_rdlvl_en, dfi_lp_ctrl_req | dfi_lp_data_req, dfi_freq_change_req, clkctl_freq_update_req};
  assign {dfi_rdlvl_resp, dfi_lp_ack, dfi_freq_change_ack, clkctl_freq_update_ack} = ack_q;

  // Slow mode stands in for a clock source that takes long to settle
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!nrst)
      begin
        ack_q[i] <= 1'b0;
        cnt_q[i] <= 4'h0;
      end
      else if (req_v[i] == ack_q[i])
        cnt_q[i] <= 4'h0;
      else if (cnt_q[i] == (slow ? 4'h9 : 4'h1))
      begin
        ack_q[i] <= req_v[i];
        cnt_q[i] <= 4'h0;
      end
      else
        cnt_q[i] <= cnt_q[i] + 4'h1;
    end
  end
endmodule

/* msb_sideband_bench.sv */
// Self-checking bench for the side-band handshake block with its far-side model.
// Assumes a 40 MHz core clock; stimulus changes at the falling edge.
`timescale 1ns/1ps
`include "msb_defines.svh"
module msb_sideband_bench;
  logic clock, nrst, slow, qreqn, core_busy, core_deny_en, qreqn_regbus, regbus_busy, regbus_deny_en;
  logic freq_change_start, abort_req, lp_ctrl_want, lp_data_want, dfi_rdlvl_req, dfi_rdlvl_periodic;
  logic rdlvl_allow, mbistresetn, mbistreq, mbistack, rdlvl_is_periodic, rdlvl_done;
  logic [`MSB_FREQ_W-1:0]  freq_target, clkctl_target_freq, dfi_frequency;
  logic [`MSB_WAKE_W-1:0]  lp_wakeup_code, dfi_lp_wakeup;
  logic [`MSB_NUM_INT-1:0] event_pulse, int_clear, int_v;
  logic [7:0]              txn_outstanding;
  logic [1:0]              dfi_rdlvl_cs_n, rdlvl_target_cs_n;
  logic qacceptn, qdeny, qactive, qacceptn_regbus, qdeny_regbus, qactive_regbus, clkctl_freq_update_req;
  logic clkctl_freq_update_ack, dfi_freq_change_req, dfi_freq_change_ack, freq_change_done, abort_ack;
  logic retry_enable, dfi_lp_ctrl_req, dfi_lp_data_req, dfi_lp_ack, lp_granted, dfi_rdlvl_en, dfi_rdlvl_resp;
  logic ram_ecc_errc_int, ram_ecc_errd_int, dram_ecc_errc_int, dram_ecc_errd_int, failed_access_int;
  logic failed_prog_int, link_err_int;
  int   err_total, comparisons, k;

  assign int_v = {link_err_int, failed_prog_int, failed_access_int, dram_ecc_errd_int, dram_ecc_errc_int,
                  ram_ecc_errd_int, ram_ecc_errc_int};

  msb_sideband #(.OUT_W(8), .CS_W(2)) u_msb_sideband (
    .clock, .nrst, .qreqn, .qacceptn, .qdeny, .qactive, .core_busy, .core_deny_en,
    .qreqn_regbus, .qacceptn_regbus, .qdeny_regbus, .qactive_regbus, .regbus_busy, .regbus_deny_en,
    .freq_change_start, .freq_target, .clkctl_target_freq, .clkctl_freq_update_req, .clkctl_freq_update_ack,
    .dfi_frequency, .dfi_freq_change_req, .dfi_freq_change_ack, .freq_change_done,
    .txn_outstanding, .abort_req, .abort_ack, .retry_enable,
    .lp_ctrl_want, .lp_data_want, .lp_wakeup_code, .dfi_lp_ctrl_req, .dfi_lp_data_req, .dfi_lp_wakeup,
    .dfi_lp_ack, .lp_granted, .dfi_rdlvl_req, .dfi_rdlvl_cs_n, .dfi_rdlvl_periodic, .rdlvl_allow,
    .dfi_rdlvl_en, .dfi_rdlvl_resp, .rdlvl_target_cs_n, .rdlvl_is_periodic, .rdlvl_done,
    .mbistresetn, .mbistreq, .mbistack, .event_pulse, .int_clear,
    .ram_ecc_errc_int, .ram_ecc_errd_int, .dram_ecc_errc_int, .dram_ecc_errd_int,
    .failed_access_int, .failed_prog_int, .link_err_int
  );

  msb_partner u_msb_partner (
    .clock, .nrst, .slow, .clkctl_freq_update_req, .dfi_freq_change_req, .dfi_lp_ctrl_req,
    .dfi_lp_data_req, .dfi_rdlvl_en, .clkctl_freq_update_ack, .dfi_freq_change_ack, .dfi_lp_ack, .dfi_rdlvl_resp
  );

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic t_reset;
    chk({qacceptn, qdeny, qacceptn_regbus, qdeny_regbus, retry_enable, abort_ack}, 6'h2a);
    chk({clkctl_freq_update_req, dfi_freq_change_req, rdlvl_target_cs_n, int_v}, 11'h180);
    $display("test reset done");
  endtask

  // Core accepts after draining while the register bus denies, then the roles swap
  task automatic t_qstop;
    {core_busy, regbus_busy, regbus_deny_en} = 3'b111;
    {qreqn, qreqn_regbus} = 2'b00;
    for (k = 0; k < 40 && qdeny_regbus !== 1'b1; k++) tick(1);
    tick(4);
    chk({qdeny_regbus, qacceptn, qacceptn_regbus, qactive, qactive_regbus, qdeny}, 6'h3e);
    core_busy = 1'b0;
    for (k = 0; k < 40 && qacceptn !== 1'b0; k++) tick(1);
    chk({qacceptn, qdeny, qactive}, 3'b000);
    {qreqn, qreqn_regbus} = 2'b11;
    tick(6);
    chk({qacceptn, qdeny_regbus, qacceptn_regbus}, 3'b101);
    {regbus_deny_en, core_deny_en} = 2'b01;
    {qreqn, qreqn_regbus} = 2'b00;
    tick(8);
    chk({qdeny, qacceptn, qacceptn_regbus}, 3'b111);
    regbus_busy = 1'b0;
    for (k = 0; k < 40 && qacceptn_regbus !== 1'b0; k++) tick(1);
    chk({qacceptn_regbus, qdeny_regbus, qactive_regbus}, 3'b000);
    {qreqn, qreqn_regbus} = 2'b11;
    core_deny_en = 1'b0;
    tick(6);
    chk({qdeny, qacceptn_regbus}, 2'b01);
    $display("test clock-stop done");
  endtask

  task automatic t_freq;
    slow = 1'b1;
    txn_outstanding = 8'h01;
    freq_target = 5'h15;
    freq_change_start = 1'b1;
    tick(1);
    freq_change_start = 1'b0;
    freq_target = 5'h0a;
    qreqn = 1'b0;
    tick(6);
    chk({clkctl_freq_update_req, dfi_freq_change_req, qdeny}, 3'b001);
    txn_outstanding = 8'h00;
    qreqn = 1'b1;
    for (k = 0; k < 40 && clkctl_freq_update_req !== 1'b1; k++) tick(1);
    chk({dfi_freq_change_req, clkctl_target_freq, dfi_frequency}, {1'b1, 5'h15, 5'h15});
    for (k = 0; k < 60 && clkctl_freq_update_req !== 1'b0; k++) tick(1);
    chk({clkctl_freq_update_ack, dfi_freq_change_ack, dfi_freq_change_req}, 3'b110);
    for (k = 0; k < 60 && freq_change_done !== 1'b1; k++) tick(1);
    chk(freq_change_done, 1'b1);
    tick(1);
    chk(freq_change_done, 1'b0);
    slow = 1'b0;
    $display("test frequency done");
  endtask

  task automatic t_abort;
    txn_outstanding = 8'h03;
    abort_req = 1'b1;
    tick(5);
    chk({retry_enable, abort_ack}, 2'b00);
    txn_outstanding = 8'h00;
    for (k = 0; k < 20 && abort_ack !== 1'b1; k++) tick(1);
    chk(abort_ack, 1'b1);
    abort_req = 1'b0;
    tick(5);
    chk({retry_enable, abort_ack}, 2'b10);
    $display("test abort done");
  endtask

  task automatic t_lowpower;
    lp_wakeup_code = 4'h9;
    lp_ctrl_want = 1'b1;
    tick(2);
    chk({dfi_lp_ctrl_req, dfi_lp_data_req, dfi_lp_wakeup}, 6'h29);
    lp_wakeup_code = 4'h3;
    lp_data_want = 1'b1;
    tick(2);
    chk({dfi_lp_ctrl_req, dfi_lp_data_req, dfi_lp_wakeup}, 6'h39);
    for (k = 0; k < 20 && lp_granted !== 1'b1; k++) tick(1);
    chk(lp_granted, 1'b1);
    {lp_ctrl_want, lp_data_want} = 2'b00;
    for (k = 0; k < 20 && lp_granted !== 1'b0; k++) tick(1);
    chk({lp_granted, dfi_lp_ctrl_req, dfi_lp_wakeup}, 6'h03);
    $display("test low-power done");
  endtask

  task automatic t_train;
    {dfi_rdlvl_cs_n, dfi_rdlvl_periodic, rdlvl_allow} = 4'b1011;
    dfi_rdlvl_req = 1'b1;
    for (k = 0; k < 20 && dfi_rdlvl_en !== 1'b1; k++) tick(1);
    chk({rdlvl_target_cs_n, rdlvl_is_periodic}, 3'b101);
    for (k = 0; k < 20 && rdlvl_done !== 1'b1; k++) tick(1);
    chk(rdlvl_done, 1'b1);
    {dfi_rdlvl_req, rdlvl_allow} = 2'b00;
    tick(20);
    chk({dfi_rdlvl_en, rdlvl_done}, 2'b00);
    $display("test training done");
  endtask

  task automatic t_mbist;
    mbistreq = 1'b1;
    for (k = 0; k < 20 && mbistack !== 1'b1; k++) tick(1);
    chk(mbistack, 1'b1);
    mbistresetn = 1'b0;
    tick(2);
    chk(mbistack, 1'b0);
    {mbistreq, mbistresetn} = 2'b01;
    tick(4);
    chk(mbistack, 1'b0);
    $display("test self-test done");
  endtask

  task automatic t_ints;
    for (int b = 0; b < `MSB_NUM_INT; b++)
    begin
      event_pulse = 7'h01 << b;
      tick(1);
      event_pulse = '0;
      chk(int_v, 7'h01 << b);
      tick(4);
      chk(int_v, 7'h01 << b);
      int_clear = 7'h01 << b;
      tick(1);
      int_clear = '0;
      chk(int_v, 7'h00);
    end
    $display("test interrupts done");
  endtask

  initial
  begin
    err_total = 0;
    comparisons = 0;
    {nrst, slow, core_busy, core_deny_en, regbus_busy, regbus_deny_en, freq_change_start, abort_req} = '0;
    {lp_ctrl_want, lp_data_want, dfi_rdlvl_req, dfi_rdlvl_periodic, rdlvl_allow, mbistresetn, mbistreq} = '0;
    {qreqn, qreqn_regbus, dfi_rdlvl_cs_n} = 4'hf;
    {freq_target, lp_wakeup_code, event_pulse, int_clear, txn_outstanding} = '0;
    tick(6);
    {nrst, mbistresetn} = 2'b11;
    tick(1);
    t_reset;
    t_qstop;
    t_freq;
    t_abort;
    t_lowpower;
    t_train;
    t_mbist;
    t_ints;
    tally_and_finish;
  end

  // Several times the expected run length, so only a hang reaches it
  initial
  begin
    repeat (4000) @(posedge clock);
    err_total++;
    tally_and_finish;
  end
endmodule
